// *** inc/sbcfs_regs.svh ***
// Register offsets, field positions, reset values and timing constants of the fault status bank
`ifndef SBCFS_REGS_SVH
`define SBCFS_REGS_SVH

`define SBCFS_ADDR_SUPPLY 7'h41
`define SBCFS_ADDR_THERMAL 7'h42
`define SBCFS_ADDR_DEVICE 7'h43
`define SBCFS_ADDR_BUS_A 7'h44

`define SBCFS_SUPPLY_RESET 8'h80
`define SBCFS_THERMAL_RESET 8'h00
`define SBCFS_DEVICE_RESET 8'h00
`define SBCFS_BUS_A_RESET 8'h00
`define SBCFS_BYTE_ZERO 8'h00

`define SBCFS_PRIOR_MSB 7
`define SBCFS_PRIOR_LSB 6
`define SBCFS_RST_STUCK_BIT 5
`define SBCFS_FSI_BIT 4
`define SBCFS_WDCNT_MSB 3
`define SBCFS_WDCNT_LSB 2
`define SBCFS_CMD_ERR_BIT 1
`define SBCFS_FO_BIT 0

`define SBCFS_PRIOR_NONE 2'h0
`define SBCFS_PRIOR_FAIL 2'h1
`define SBCFS_PRIOR_SLEEP 2'h2

`define SBCFS_WD_NONE 2'h0
`define SBCFS_WD_ONE 2'h1
`define SBCFS_WD_TWO 2'h2

`define SBCFS_CODE_NONE 2'h0
`define SBCFS_CODE_TSD 2'h1
`define SBCFS_CODE_TXD 2'h2
`define SBCFS_CODE_BUS 2'h3

`define SBCFS_CLK_PERIOD_NS 25
`define SBCFS_TXEN_TIME_NS 10000
`define SBCFS_TXEN_CYCLES ((`SBCFS_TXEN_TIME_NS + `SBCFS_CLK_PERIOD_NS - 1) / `SBCFS_CLK_PERIOD_NS)

`endif

// *** inc/sbcfs_pkg.sv ***
// Types shared by the fault status bank and its transmitter enable gate
package sbcfs_pkg;

  // Transceiver operating mode, one-hot
  typedef enum logic [3:0] {
    SBCFS_MODE_OFF = 4'h1,
    SBCFS_MODE_WAKE = 4'h2,
    SBCFS_MODE_RXONLY = 4'h4,
    SBCFS_MODE_NORMAL = 4'h8
  } sbcfs_mode_e;

  // Transmitter enable gate states, one-hot
  typedef enum logic [2:0] {
    SBCFS_TX_BLOCKED = 3'h1,
    SBCFS_TX_WAIT = 3'h2,
    SBCFS_TX_ENABLED = 3'h4
  } sbcfs_txst_e;

  // Serial command as decoded by the frame logic
  typedef struct packed {
    logic clear;
    logic [6:0] addr;
    logic [7:0] data;
  } sbcfs_cmd_s;

  // Regulator and supply detector levels
  typedef struct packed {
    logic por;
    logic lin_low;
    logic main_over;
    logic aux_hot;
    logic aux_low;
    logic main_short;
    logic main_low;
    logic main_on;
    logic aux_on;
    logic lin_any_active;
  } sbcfs_supply_s;

  // Per-transceiver detector levels
  typedef struct packed {
    logic tsd;
    logic txd_timeout;
    logic bus_timeout;
    logic txd_high;
    logic bus_recessive;
    sbcfs_mode_e mode;
  } sbcfs_chan_s;

endpackage : sbcfs_pkg

// *** rtl/sbcfs_txen.sv ***
// Transmitter enable gate: holds a transmitter off until its input has idled high long enough
`timescale 1ns/10ps
`include "sbcfs_regs.svh"
module sbcfs_txen #(
  parameter int unsigned EN_CYCLES = `SBCFS_TXEN_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fault,
  input wire logic txd_high,
  output logic tx_enable
);

  localparam int unsigned CW = $clog2(EN_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(EN_CYCLES - 1);

  sbcfs_pkg::sbcfs_txst_e state;
  logic [CW-1:0] count;

  // Blocked on any fault; a low transmit input restarts the wait
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= sbcfs_pkg::SBCFS_TX_BLOCKED;
      count <= '0;
    end else begin
      case (state)
        sbcfs_pkg::SBCFS_TX_BLOCKED: begin
          count <= '0;
          if (!fault && txd_high) begin
            state <= sbcfs_pkg::SBCFS_TX_WAIT;
          end
        end
        sbcfs_pkg::SBCFS_TX_WAIT: begin
          if (fault || !txd_high) begin
            state <= sbcfs_pkg::SBCFS_TX_BLOCKED;
          end else if (count == LAST) begin
            state <= sbcfs_pkg::SBCFS_TX_ENABLED;
          end else begin
            count <= count + 1'b1;
          end
        end
        sbcfs_pkg::SBCFS_TX_ENABLED: begin
          if (fault) begin
            state <= sbcfs_pkg::SBCFS_TX_BLOCKED;
          end
        end
        default: begin
          state <= sbcfs_pkg::SBCFS_TX_BLOCKED;
        end
      endcase
    end
  end

  // Registered enable output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_enable <= 1'b0;
    end else begin
      tx_enable <= (state == sbcfs_pkg::SBCFS_TX_ENABLED) && !fault;
    end
  end

endmodule : sbcfs_txen

// *** rtl/sbcfs_top.sv ***
// Fault status register bank: latches supply, thermal, device and bus faults, read and cleared by command
`timescale 1ns/10ps
`include "sbcfs_regs.svh"
module sbcfs_top #(
  parameter int unsigned TXEN_CYCLES = `SBCFS_TXEN_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  // Command port from the serial frame logic
  input wire logic cmd_valid,
  input wire logic cmd_invalid,
  input wire sbcfs_pkg::sbcfs_cmd_s cmd,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // Detector levels
  input wire sbcfs_pkg::sbcfs_supply_s supply,
  input wire logic thermal_prewarning,
  input wire logic thermal_level_one,
  input wire logic thermal_level_two,
  input wire logic reset_line_stuck,
  input wire logic failsafe_input_error,
  input wire logic watchdog_fail_event,
  input wire logic watchdog_trigger_ok,
  input wire logic wake_from_sleep,
  input wire logic wake_from_failsafe,
  input wire logic reset_on_overvoltage_enable,
  input wire logic fail_cfg_single,
  input wire sbcfs_pkg::sbcfs_chan_s can_chan,
  input wire sbcfs_pkg::sbcfs_chan_s lin_chan,
  input wire logic can_supply_low,
  input wire logic can_wake_pattern_seen,
  // Device reactions
  output logic failsafe_mode,
  output logic fail_outputs,
  output logic can_tx_enable,
  output logic lin_tx_enable
);

  // Status bytes
  logic [7:0] supply_fault_status;
  logic [7:0] thermal_status;
  logic [5:0] dev_flags;
  logic [1:0] prior_state_field;
  logic [1:0] watchdog_failure_counter;
  logic [1:0] chan_code [2];
  logic can_supply_low_flag;

  // Command decode
  logic exec;
  logic clr_supply;
  logic clr_thermal;
  logic clr_device;
  logic clr_bus_a;
  logic [7:0] read_mux;

  // Event vectors
  logic [7:0] supply_set;
  logic [7:0] thermal_set;
  logic failure_restart;
  logic can_uv_active;
  logic can_uv_set;

  // Per-channel views
  sbcfs_pkg::sbcfs_chan_s chan [2];
  logic [1:0] chan_new_code [2];
  logic chan_fault [2];
  logic chan_tx_en [2];
  logic chan_tsd_any;

  assign chan[0] = can_chan;
  assign chan[1] = lin_chan;

  // Invalid commands are never executed, so they clear nothing
  assign exec = cmd_valid && !cmd_invalid;
  assign clr_supply = exec && cmd.clear && (cmd.addr == `SBCFS_ADDR_SUPPLY);
  assign clr_thermal = exec && cmd.clear && (cmd.addr == `SBCFS_ADDR_THERMAL);
  assign clr_device = exec && cmd.clear && (cmd.addr == `SBCFS_ADDR_DEVICE);
  assign clr_bus_a = exec && cmd.clear && (cmd.addr == `SBCFS_ADDR_BUS_A);

  // Supply flags other than por and main_over, gated by whether the monitored source is on
  always_comb begin
    supply_set = `SBCFS_BYTE_ZERO;
    supply_set[7] = supply.por;
    supply_set[6] = supply.lin_low && supply.lin_any_active;
    supply_set[5] = supply.main_over;
    supply_set[4] = supply.aux_hot && supply.aux_on;
    supply_set[3] = supply.aux_low && supply.aux_on;
    supply_set[2] = supply.main_short && supply.main_on;
    supply_set[0] = supply.main_low && supply.main_on;
  end

  // Transceiver thermal shutdown also shows as level one
  assign chan_tsd_any = chan[0].tsd || chan[1].tsd;

  always_comb begin
    thermal_set = `SBCFS_BYTE_ZERO;
    thermal_set[2] = thermal_level_two;
    thermal_set[1] = thermal_level_one || chan_tsd_any;
    thermal_set[0] = thermal_prewarning;
  end

  // Supply byte; set has priority over a same-cycle clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      supply_fault_status <= `SBCFS_SUPPLY_RESET;
    end else begin
      supply_fault_status <= (supply_fault_status & ~{8{clr_supply}}) | supply_set;
    end
  end

  // Thermal byte
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      thermal_status <= `SBCFS_THERMAL_RESET;
    end else begin
      thermal_status <= (thermal_status & ~{8{clr_thermal}}) | thermal_set;
    end
  end

  // Level-two shutdown parks the device in fail-safe until it wakes out
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      failsafe_mode <= 1'b0;
    end else if (thermal_level_two) begin
      failsafe_mode <= 1'b1;
    end else if (wake_from_failsafe) begin
      failsafe_mode <= 1'b0;
    end
  end

  // Causes that count as a failure restart
  assign failure_restart = watchdog_fail_event || thermal_level_two
    || (supply.main_low && supply.main_on)
    || (supply.main_over && reset_on_overvoltage_enable);

  // Prior-state: failure beats sleep wake; only a clear returns it to none
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prior_state_field <= `SBCFS_PRIOR_NONE;
    end else if (failure_restart || wake_from_failsafe) begin
      prior_state_field <= `SBCFS_PRIOR_FAIL;
    end else if (wake_from_sleep) begin
      prior_state_field <= `SBCFS_PRIOR_SLEEP;
    end else if (clr_device) begin
      prior_state_field <= `SBCFS_PRIOR_NONE;
    end
  end

  // Watchdog failure counter saturates at two; clear commands leave it alone
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      watchdog_failure_counter <= `SBCFS_WD_NONE;
    end else if (watchdog_fail_event) begin
      if (watchdog_failure_counter != `SBCFS_WD_TWO) begin
        watchdog_failure_counter <= watchdog_failure_counter + 1'b1;
      end
    end else if (watchdog_trigger_ok) begin
      watchdog_failure_counter <= `SBCFS_WD_NONE;
    end
  end

  // Fail outputs follow fail-safe or the counter and configuration
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fail_outputs <= 1'b0;
    end else begin
      fail_outputs <= failsafe_mode
        || (watchdog_failure_counter == `SBCFS_WD_TWO)
        || (fail_cfg_single && (watchdog_failure_counter == `SBCFS_WD_ONE));
    end
  end

  // Remaining device flags, held in their byte positions
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dev_flags <= 6'(`SBCFS_DEVICE_RESET);
    end else begin
      if (clr_device) begin
        dev_flags <= '0;
      end
      if (reset_line_stuck) begin
        dev_flags[`SBCFS_RST_STUCK_BIT] <= 1'b1;
      end
      if (failsafe_input_error) begin
        dev_flags[`SBCFS_FSI_BIT] <= 1'b1;
      end
      if (cmd_valid && cmd_invalid) begin
        dev_flags[`SBCFS_CMD_ERR_BIT] <= 1'b1;
      end
      if (fail_outputs) begin
        dev_flags[`SBCFS_FO_BIT] <= 1'b1;
      end
    end
  end

  // CAN supply comparator only listens in the allowed modes
  assign can_uv_active = (can_chan.mode == sbcfs_pkg::SBCFS_MODE_NORMAL)
    || (can_chan.mode == sbcfs_pkg::SBCFS_MODE_RXONLY)
    || ((can_chan.mode == sbcfs_pkg::SBCFS_MODE_WAKE) && can_wake_pattern_seen);
  assign can_uv_set = can_supply_low && can_uv_active;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      can_supply_low_flag <= 1'b0;
    end else if (can_uv_set) begin
      can_supply_low_flag <= 1'b1;
    end else if (clr_bus_a) begin
      can_supply_low_flag <= 1'b0;
    end
  end

  // One slice per transceiver: index 0 is CAN, index 1 is LIN channel one
  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic txd_stuck;
    logic bus_stuck;
    logic idle_mode;
    logic [1:0] kept_code;

    assign idle_mode = (chan[i].mode == sbcfs_pkg::SBCFS_MODE_OFF)
      || (chan[i].mode == sbcfs_pkg::SBCFS_MODE_WAKE);

    // Bus stuck outranks transmit stuck, which outranks thermal
    always_comb begin
      if (chan[i].bus_timeout) begin
        chan_new_code[i] = `SBCFS_CODE_BUS;
      end else if (chan[i].txd_timeout) begin
        chan_new_code[i] = `SBCFS_CODE_TXD;
      end else if (chan[i].tsd) begin
        chan_new_code[i] = `SBCFS_CODE_TSD;
      end else begin
        chan_new_code[i] = `SBCFS_CODE_NONE;
      end
    end

    // Latched code keeps the most severe event since the last clear
    assign kept_code = clr_bus_a ? `SBCFS_CODE_NONE : chan_code[i];

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        chan_code[i] <= `SBCFS_CODE_NONE;
      end else if (chan_new_code[i] > kept_code) begin
        chan_code[i] <= chan_new_code[i];
      end else begin
        chan_code[i] <= kept_code;
      end
    end

    // Live transmit-stuck condition and its recovery
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        txd_stuck <= 1'b0;
      end else if (chan[i].txd_timeout) begin
        txd_stuck <= 1'b1;
      end else if (chan[i].txd_high || idle_mode) begin
        txd_stuck <= 1'b0;
      end
    end

    // Live bus-stuck condition and its recovery
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        bus_stuck <= 1'b0;
      end else if (chan[i].bus_timeout) begin
        bus_stuck <= 1'b1;
      end else if (chan[i].bus_recessive || idle_mode) begin
        bus_stuck <= 1'b0;
      end
    end

    // Supply low lasts only while the comparator still reports it
    if (i == 0) begin : g_can
      assign chan_fault[i] = chan[i].tsd || txd_stuck || bus_stuck || can_uv_set;
    end else begin : g_lin
      assign chan_fault[i] = chan[i].tsd || txd_stuck || bus_stuck
        || (supply.lin_low && supply.lin_any_active);
    end

    sbcfs_txen #(
      .EN_CYCLES(TXEN_CYCLES)
    ) u_txen (
      .core_clk(core_clk),
      .rst(rst),
      .fault(chan_fault[i]),
      .txd_high(chan[i].txd_high),
      .tx_enable(chan_tx_en[i])
    );
  end

  // Enables already come from flip-flops; re-registered to keep outputs direct
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      can_tx_enable <= 1'b0;
      lin_tx_enable <= 1'b0;
    end else begin
      can_tx_enable <= chan_tx_en[0] && !chan_fault[0];
      lin_tx_enable <= chan_tx_en[1] && !chan_fault[1];
    end
  end

  // Read data before any clear of the same command; reserved bits forced low
  always_comb begin
    read_mux = `SBCFS_BYTE_ZERO;
    case (cmd.addr)
      `SBCFS_ADDR_SUPPLY: begin
        read_mux = supply_fault_status;
        read_mux[1] = 1'b0;
      end
      `SBCFS_ADDR_THERMAL: begin
        read_mux = {5'h00, thermal_status[2:0]};
      end
      `SBCFS_ADDR_DEVICE: begin
        read_mux[`SBCFS_PRIOR_MSB:`SBCFS_PRIOR_LSB] = prior_state_field;
        read_mux[`SBCFS_WDCNT_MSB:`SBCFS_WDCNT_LSB] = watchdog_failure_counter;
        read_mux[`SBCFS_RST_STUCK_BIT] = dev_flags[`SBCFS_RST_STUCK_BIT];
        read_mux[`SBCFS_FSI_BIT] = dev_flags[`SBCFS_FSI_BIT];
        read_mux[`SBCFS_CMD_ERR_BIT] = dev_flags[`SBCFS_CMD_ERR_BIT];
        read_mux[`SBCFS_FO_BIT] = dev_flags[`SBCFS_FO_BIT];
      end
      `SBCFS_ADDR_BUS_A: begin
        read_mux = {1'b0, chan_code[1], 2'h0, chan_code[0], can_supply_low_flag};
      end
      default: begin
        read_mux = `SBCFS_BYTE_ZERO;
      end
    endcase
  end

  // One answer per command, one cycle later; refused commands answer zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= `SBCFS_BYTE_ZERO;
    end else begin
      rsp_valid <= cmd_valid;
      if (cmd_valid) begin
        rsp_data <= exec ? read_mux : `SBCFS_BYTE_ZERO;
      end
    end
  end

endmodule : sbcfs_top

// *** verif/sbcfs_top_asserts.sv ***
// Port-level property checker for the fault status bank
`timescale 1ns/10ps
module sbcfs_top_asserts #(
  parameter int unsigned TXEN_CYCLES = 400
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_invalid,
  input wire sbcfs_pkg::sbcfs_cmd_s cmd,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic thermal_level_two,
  input wire logic watchdog_fail_event,
  input wire logic fail_cfg_single,
  input wire sbcfs_pkg::sbcfs_chan_s can_chan,
  input wire logic can_supply_low,
  input wire logic failsafe_mode,
  input wire logic fail_outputs,
  input wire logic can_tx_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Idle-high run of the CAN transmit input; saturates so it never wraps
  logic [15:0] hi_cnt;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hi_cnt <= 16'h0000;
    end else if (!can_chan.txd_high) begin
      hi_cnt <= 16'h0000;
    end else if (hi_cnt != 16'hFFFF) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end

  rsp_timing_a: assert property (cmd_valid |=> rsp_valid)
    else $error("answer not one cycle after command");
  refused_data_a: assert property (cmd_valid && cmd_invalid |=> rsp_data == 8'h00)
    else $error("refused command returned data");
  supply_rsvd_a: assert property (cmd_valid && cmd.addr == 7'h41 |=> !rsp_data[1])
    else $error("supply reserved bit set");
  therm_rsvd_a: assert property (cmd_valid && cmd.addr == 7'h42 |=> rsp_data[7:3] == 5'h00)
    else $error("thermal reserved bits set");
  dev_codes_a: assert property (cmd_valid && cmd.addr == 7'h43 |=> rsp_data[3:2] != 2'h3 && rsp_data[7:6] != 2'h3)
    else $error("device byte shows unused code");
  failsafe_entry_a: assert property (thermal_level_two |-> ##[1:2] failsafe_mode)
    else $error("level two shutdown missed fail-safe");
  watchdog_failure_counter_out_a: assert property (watchdog_fail_event && fail_cfg_single |-> ##[1:3] fail_outputs)
    else $error("watchdog fail did not raise fail outputs");
  can_uv_off_a: assert property (can_supply_low && can_chan.mode == sbcfs_pkg::SBCFS_MODE_NORMAL
    |-> ##[1:2] !can_tx_enable)
    else $error("transmitter on during supply low");
  tsd_off_a: assert property (can_chan.tsd |-> ##[1:2] !can_tx_enable)
    else $error("transmitter on during thermal fault");
  tx_reenable_a: assert property ($rose(can_tx_enable) |-> hi_cnt >= TXEN_CYCLES)
    else $error("transmitter enabled too early");

  clear_cmd_c: cover property (cmd_valid && cmd.clear);
  failsafe_c: cover property ($rose(failsafe_mode));
  tx_back_c: cover property ($rose(can_tx_enable));
endmodule : sbcfs_top_asserts

bind sbcfs_top sbcfs_top_asserts #(.TXEN_CYCLES(TXEN_CYCLES)) u_chk (
  .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_invalid(cmd_invalid),
  .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .thermal_level_two(thermal_level_two),
  .watchdog_fail_event(watchdog_fail_event), .fail_cfg_single(fail_cfg_single),
  .can_chan(can_chan), .can_supply_low(can_supply_low), .failsafe_mode(failsafe_mode),
  .fail_outputs(fail_outputs), .can_tx_enable(can_tx_enable)
);

// *** verif/sbcfs_mcu_model.sv ***
// Command master model standing in for the microcontroller side
`timescale 1ns/10ps
module sbcfs_mcu_model (
  input wire logic core_clk,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  output logic cmd_valid,
  output logic cmd_invalid,
  output sbcfs_pkg::sbcfs_cmd_s cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd_invalid = 1'b0;
    cmd = '0;
  end

  // One command; lines flip once released so stale values never look valid
  task automatic xf(input logic c, input logic [6:0] a, input logic inv, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_invalid = inv;
    cmd.clear = c;
    cmd.addr = a;
    cmd.data = 8'hA5;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_invalid = 1'b0;
    cmd = ~cmd;
    d = (rsp_valid === 1'b1) ? rsp_data : 8'hXX;
  endtask : xf
endmodule : sbcfs_mcu_model

// *** verif/sbc_fault_status_registers_test.sv ***
// Self-checking bench for the fault status bank
`timescale 1ns/10ps
module sbc_fault_status_registers_test;
  logic core_clk, rst, cmd_valid, cmd_invalid, rsp_valid, tp, t1, t2, rls, fse, wfe, wok, wsl, wfs, roe, fcs;
  logic csl, cwp, fsm, fo, cte, lte;
  logic [7:0] rsp_data, d, e;
  sbcfs_pkg::sbcfs_cmd_s cmd;
  sbcfs_pkg::sbcfs_supply_s supply;
  sbcfs_pkg::sbcfs_chan_s can_chan, lin_chan;
  int err_count, checks, cyc, i;

  sbcfs_top #(.TXEN_CYCLES(4)) u_dut (
    .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_invalid(cmd_invalid), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .supply(supply), .thermal_prewarning(tp),
    .thermal_level_one(t1), .thermal_level_two(t2), .reset_line_stuck(rls), .failsafe_input_error(fse),
    .watchdog_fail_event(wfe), .watchdog_trigger_ok(wok), .wake_from_sleep(wsl), .wake_from_failsafe(wfs),
    .reset_on_overvoltage_enable(roe), .fail_cfg_single(fcs), .can_chan(can_chan), .lin_chan(lin_chan),
    .can_supply_low(csl), .can_wake_pattern_seen(cwp), .failsafe_mode(fsm), .fail_outputs(fo),
    .can_tx_enable(cte), .lin_tx_enable(lte)
  );

  sbcfs_mcu_model u_mcu (
    .core_clk(core_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .cmd_valid(cmd_valid), .cmd_invalid(cmd_invalid), .cmd(cmd)
  );

  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tk

  task automatic cmp(input logic [7:0] g, input logic [7:0] x);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, x);
    end
  endtask : cmp

  // Read a byte and compare the masked bits
  task automatic ck(input logic [6:0] a, input logic [7:0] m, input logic [7:0] x);
    logic [7:0] r;
    u_mcu.xf(1'b0, a, 1'b0, r);
    cmp(r & m, x);
  endtask : ck

  // Clear a byte; the answer carries the value from before the clear
  task automatic cl(input logic [6:0] a, input logic [7:0] m, input logic [7:0] x);
    logic [7:0] r;
    u_mcu.xf(1'b1, a, 1'b0, r);
    cmp(r & m, x);
  endtask : cl

  task end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim;
    end
  end

  initial begin
    rst = 1'b1;
    {tp, t1, t2, rls, fse, wfe, wok, wsl, wfs, roe, fcs, csl, cwp} = '0;
    supply = '0;
    supply[2:0] = 3'h7;
    can_chan = '0;
    can_chan.txd_high = 1'b1;
    can_chan.bus_recessive = 1'b1;
    can_chan.mode = sbcfs_pkg::SBCFS_MODE_NORMAL;
    lin_chan = can_chan;
    tk(8);
    rst = 1'b0;
    ck(7'h41, 8'hFF, 8'h80);
    ck(7'h42, 8'hFF, 8'h00);
    ck(7'h43, 8'hFF, 8'h00);
    ck(7'h44, 8'hFF, 8'h00);
    ck(7'h45, 8'hFF, 8'h00);
    cl(7'h41, 8'hFF, 8'h80);
    ck(7'h41, 8'hFF, 8'h00);
    $display("test reset done");
    // Each supply detector except por in turn, regulators on
    for (i = 0; i < 6; i++) begin
      supply[8-i] = 1'b1;
      tk(1);
      supply[8-i] = 1'b0;
      tk(2);
      e = (i < 5) ? (8'h40 >> i) : 8'h01;
      ck(7'h41, 8'hFF, e);
      ck(7'h41, 8'hFF, e);
      cl(7'h41, 8'hFF, e);
    end
    cl(7'h43, 8'hC0, 8'h40);
    supply[2:0] = 3'h0;
    supply[8:3] = 6'h3F;
    tk(2);
    supply[8:3] = 6'h00;
    tk(2);
    ck(7'h41, 8'hFF, 8'h20);
    supply[2:0] = 3'h7;
    cl(7'h41, 8'hFF, 8'h20);
    roe = 1'b1;
    supply.main_over = 1'b1;
    tk(1);
    supply.main_over = 1'b0;
    tk(2);
    ck(7'h43, 8'hC0, 8'h40);
    roe = 1'b0;
    cl(7'h41, 8'hFF, 8'h20);
    cl(7'h43, 8'h00, 8'h00);
    $display("test supply done");
    {tp, t1, t2} = 3'h7;
    tk(1);
    {tp, t1, t2} = 3'h0;
    tk(2);
    ck(7'h42, 8'hFF, 8'h07);
    cmp({7'h0, fsm}, 8'h01);
    ck(7'h43, 8'hC0, 8'h40);
    wfs = 1'b1;
    tk(1);
    wfs = 1'b0;
    tk(2);
    cl(7'h42, 8'hFF, 8'h07);
    cl(7'h43, 8'hC0, 8'h40);
    ck(7'h43, 8'hC0, 8'h00);
    tp = 1'b1;
    tk(1);
    cl(7'h42, 8'hFF, 8'h01);
    ck(7'h42, 8'hFF, 8'h01);
    tp = 1'b0;
    cl(7'h42, 8'hFF, 8'h01);
    $display("test thermal done");
    fcs = 1'b1;
    for (i = 1; i < 4; i++) begin
      wfe = 1'b1;
      tk(1);
      wfe = 1'b0;
      tk(2);
      e = (i < 3) ? 8'(i << 2) : 8'h08;
      ck(7'h43, 8'h0C, e);
    end
    cmp({7'h0, fo}, 8'h01);
    ck(7'h43, 8'h01, 8'h01);
    cl(7'h43, 8'h0C, 8'h08);
    ck(7'h43, 8'h0C, 8'h08);
    wok = 1'b1;
    tk(1);
    wok = 1'b0;
    tk(2);
    ck(7'h43, 8'h0C, 8'h00);
    cl(7'h43, 8'h00, 8'h00);
    wsl = 1'b1;
    tk(1);
    wsl = 1'b0;
    tk(2);
    ck(7'h43, 8'hC0, 8'h80);
    $display("test watchdog done");
    tp = 1'b1;
    tk(1);
    tp = 1'b0;
    u_mcu.xf(1'b1, 7'h42, 1'b1, d);
    cmp(d, 8'h00);
    ck(7'h42, 8'hFF, 8'h01);
    ck(7'h43, 8'h02, 8'h02);
    cl(7'h43, 8'h02, 8'h02);
    ck(7'h43, 8'h02, 8'h00);
    cl(7'h42, 8'hFF, 8'h01);
    {rls, fse} = 2'h3;
    tk(1);
    {rls, fse} = 2'h0;
    tk(2);
    ck(7'h43, 8'h30, 8'h30);
    $display("test device done");
    can_chan.tsd = 1'b1;
    tk(1);
    can_chan.tsd = 1'b0;
    tk(2);
    ck(7'h44, 8'hFF, 8'h02);
    can_chan.txd_timeout = 1'b1;
    tk(1);
    can_chan.txd_timeout = 1'b0;
    tk(2);
    ck(7'h44, 8'hFF, 8'h04);
    lin_chan.bus_timeout = 1'b1;
    tk(1);
    lin_chan.bus_timeout = 1'b0;
    tk(2);
    cmp({7'h0, lte}, 8'h00);
    cl(7'h44, 8'hFF, 8'h64);
    can_chan.mode = sbcfs_pkg::SBCFS_MODE_OFF;
    csl = 1'b1;
    tk(3);
    ck(7'h44, 8'hFF, 8'h00);
    can_chan.mode = sbcfs_pkg::SBCFS_MODE_WAKE;
    tk(3);
    ck(7'h44, 8'hFF, 8'h00);
    cwp = 1'b1;
    tk(3);
    ck(7'h44, 8'h01, 8'h01);
    cwp = 1'b0;
    can_chan.mode = sbcfs_pkg::SBCFS_MODE_NORMAL;
    tk(3);
    cmp({7'h0, cte}, 8'h00);
    // Low transmit input after the fault restarts the enable wait
    csl = 1'b0;
    can_chan.txd_high = 1'b0;
    tk(2);
    can_chan.txd_high = 1'b1;
    tk(3);
    cmp({7'h0, cte}, 8'h00);
    for (i = 0; i < 40 && cte !== 1'b1; i++) tk(1);
    cmp({7'h0, cte}, 8'h01);
    cmp({7'h0, lte}, 8'h01);
    cl(7'h44, 8'h01, 8'h01);
    $display("test bus done");
    end_sim;
  end
endmodule : sbc_fault_status_registers_test
